/* File: src/srcc_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz block clock, APB byte addressing
// Notes:   Definitions only
`ifndef SRCC_MAP_SVH
`define SRCC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SRCC_OFS_STRAP   12'h000
`define SRCC_OFS_CLKCTL  12'h004
`define SRCC_OFS_WDCTL   12'h008
`define SRCC_OFS_WDIVL   12'h00c
`define SRCC_OFS_WDCNT   12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SRCC_WD_EN_BIT    0
`define SRCC_WD_KICK_BIT  1
`define SRCC_WD_FIRE_BIT  8

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SRCC_CLK_RST     3'h4
`define SRCC_CLK_MAX     3'h4
`define SRCC_WDIVL_RST   24'hffffff
`define SRCC_PIN_RST     7'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRCC_CLK_NS      100
`define SRCC_HOLD_MS     200
`define SRCC_HOLD_CYC    ((`SRCC_HOLD_MS * 1000000) / `SRCC_CLK_NS)

`endif

/* File: src/srcc_pkg.sv */
// Purpose: Types shared by the strap, reset and clock block
// Assumes: Constants live in srcc_map.svh
// Notes:   Carrier structs for APB and configuration outputs
package srcc_pkg;

    // ------------------------------------------------------------
    // APB carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } srcc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } srcc_apb_rsp_t;

    // ------------------------------------------------------------
    // Captured boot straps
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRCC_W_RSVD = 2'b00,
        SRCC_W_8    = 2'b01,
        SRCC_W_16   = 2'b10,
        SRCC_W_32   = 2'b11
    } srcc_width_t;

    typedef struct packed {
        srcc_width_t bank_width;  // Bank zero data width
        logic        rst_pol;     // 1 = reset out active low
        logic        cpu_clk_byp; // 1 = PLL bypassed
        logic        host_bridge; // 1 = host, 0 = guest
        logic        test_en;     // Factory test requested
    } srcc_strap_t;

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    typedef struct packed {
        srcc_width_t bank0_width;
        logic        pll_bypass;
        logic [2:0]  pll_freq_sel;    // 0..4 = 25..125 MHz
        logic        pci_arb_en;
        logic        pci_target_only;
        logic        factory_test;
        logic        sdram_capture_fb;
    } srcc_cfg_t;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_HOLD  = 2'b01,
        ST_RUN   = 2'b10
    } srcc_state_t;

endpackage

/* File: src/srcc_pin_sync.sv */
// Purpose: Three-stage synchroniser for strap and reset pins
// Assumes: Inputs asynchronous to ref_clk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module srcc_pin_sync #(
    parameter int           W       = 7,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;   // First stage, read only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;    // Agreed level
    } srcc_sync_t;

    srcc_sync_t s;
    srcc_sync_t next_s;

    // Per-bit agreement filter
    always_comb
    begin
        next_s    = s;
        next_s.s1 = pin_in;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++)
        begin
            if (s.s2[i] == s.s3[i])
            begin
                next_s.q[i] = s.s3[i];
            end
        end
    end

    // Register stage
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign pin_q = s.q;

endmodule

`default_nettype wire

/* File: src/srcc_top.sv */
// Purpose: Boot strap capture, system reset output, clock setup
// Assumes: 10 MHz ref_clk, APB slave, arst_n is power-on reset
// Notes:   Chip reset pin and straps pass three-stage sync
//
// What this block does
// - Sample all straps while chip reset asserted
// - Width strap 01/10/11 gives 8/16/32, 00 reserved
// - Polarity strap low high-active, high low-active
// - Clock strap low uses PLL, high bypasses
// - Bridge strap low guest, high host mode
// - Guest mode: target only, arbiter disabled
// - One system reset output, strap-chosen level
// - Watchdog expiry resets block, asserts reset out
// - Reset output held at least 200 ms
// - PLL makes system clock from 25 MHz
// - System clock 25..125 MHz via 0x0004
// - SDRAM read data taken on feedback clock
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "srcc_map.svh"

module srcc_top
    import srcc_pkg::*;
#(
    parameter int HOLD_W       = 22,
    parameter int RST_HOLD_CYC = `SRCC_HOLD_CYC
) (
    // Clock and power-on reset
    input  wire logic                   ref_clk,
    input  wire logic                   arst_n,
    // APB slave
    input  wire srcc_pkg::srcc_apb_req_t apb_req,
    output var  srcc_pkg::srcc_apb_rsp_t apb_rsp,
    // Strap and reset pins
    input  wire logic [1:0]             boot_bank_width_strap,
    input  wire logic                   reset_out_polarity_strap,
    input  wire logic                   cpu_clock_source_strap,
    input  wire logic                   bridge_mode_strap,
    input  wire logic                   chip_test_enable,
    input  wire logic                   chip_reset_n,
    // System reset and configuration
    output logic                        system_reset_out,
    output var  srcc_pkg::srcc_cfg_t    cfg
);
    import srcc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        srcc_state_t   st;        // Sequencer state
        logic [HOLD_W-1:0] cnt;   // Reset hold counter
        srcc_strap_t   strap;     // Captured straps
        logic [2:0]    clk_code;  // System clock setting
        logic          wd_en;     // Watchdog running
        logic [23:0]   wd_ivl;    // Watchdog interval
        logic [23:0]   wd_cnt;    // Watchdog count
        logic          wd_fired;  // Sticky watchdog flag
        logic          rst_out;   // Pin level
        srcc_cfg_t     cfg;       // Configuration outputs
        srcc_apb_rsp_t rsp;       // APB answer
    } srcc_top_t;

    srcc_top_t         s;
    srcc_top_t         next_s;
    logic [6:0]        pin_q;     // Synced pins
    srcc_strap_t       pin_strap; // Synced straps
    logic              pin_rst_n; // Synced chip reset
    logic              wd_expire; // Watchdog reached interval
    logic              hold_done; // Hold time reached
    logic              wr_acc;    // Write taken this edge
    logic              setup;     // APB setup cycle
    localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(RST_HOLD_CYC);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    srcc_pin_sync #(
        .W       (7),
        .RST_VAL (`SRCC_PIN_RST)
    ) u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pin_in  ({chip_reset_n, boot_bank_width_strap,
                   reset_out_polarity_strap, cpu_clock_source_strap,
                   bridge_mode_strap, chip_test_enable}),
        .pin_q   (pin_q)
    );

    assign pin_strap = srcc_strap_t'(pin_q[5:0]);
    assign pin_rst_n = pin_q[6];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_s    = s;
        setup     = apb_req.psel & ~apb_req.penable;
        wr_acc    = apb_req.psel & apb_req.penable & s.rsp.pready
                    & apb_req.pwrite;
        hold_done = (s.cnt >= HOLD_CYC);
        wd_expire = (s.st == ST_RUN) && s.wd_en
                    && (s.wd_cnt >= s.wd_ivl);

        // APB answer loads at setup, stands for the access cycle
        next_s.rsp.pready  = setup;
        next_s.rsp.pslverr = 1'b0;
        next_s.rsp.prdata  = 32'h0000_0000;
        if (setup && !apb_req.pwrite)
        begin
            unique case (apb_req.paddr)
                `SRCC_OFS_STRAP:  next_s.rsp.prdata = {26'h0, s.strap};
                `SRCC_OFS_CLKCTL: next_s.rsp.prdata = {29'h0, s.clk_code};
                `SRCC_OFS_WDCTL:  next_s.rsp.prdata =
                    {23'h0, s.wd_fired, 7'h00, s.wd_en};
                `SRCC_OFS_WDIVL:  next_s.rsp.prdata = {8'h00, s.wd_ivl};
                `SRCC_OFS_WDCNT:  next_s.rsp.prdata = {8'h00, s.wd_cnt};
                default:          next_s.rsp.pslverr = 1'b1;
            endcase
        end
        else if (setup)
        begin
            // Unmapped write address or read-only target
            unique case (apb_req.paddr)
                `SRCC_OFS_CLKCTL, `SRCC_OFS_WDCTL,
                `SRCC_OFS_WDIVL:  next_s.rsp.pslverr = 1'b0;
                default:          next_s.rsp.pslverr = 1'b1;
            endcase
        end

        // Register writes take effect at the access edge
        if (wr_acc)
        begin
            unique case (apb_req.paddr)
                `SRCC_OFS_CLKCTL:
                begin
                    // Codes above the top setting clamp to 125 MHz
                    if (apb_req.pwdata[2:0] > `SRCC_CLK_MAX)
                        next_s.clk_code = `SRCC_CLK_MAX;
                    else
                        next_s.clk_code = apb_req.pwdata[2:0];
                end
                `SRCC_OFS_WDCTL:
                begin
                    next_s.wd_en = apb_req.pwdata[`SRCC_WD_EN_BIT];
                    // Kick or disable restarts the count
                    if (apb_req.pwdata[`SRCC_WD_KICK_BIT]
                        || !apb_req.pwdata[`SRCC_WD_EN_BIT])
                        next_s.wd_cnt = 24'h000000;
                    // Write one clears the sticky flag
                    if (apb_req.pwdata[`SRCC_WD_FIRE_BIT])
                        next_s.wd_fired = 1'b0;
                end
                `SRCC_OFS_WDIVL:  next_s.wd_ivl = apb_req.pwdata[23:0];
                default:          next_s.wd_ivl = s.wd_ivl;
            endcase
        end

        // Sequencer
        unique case (s.st)
            ST_STRAP:
            begin
                // Straps follow the pins while reset is held
                next_s.strap = pin_strap;
                if (!hold_done)
                    next_s.cnt = s.cnt + HOLD_W'(1);
                // Release freezes the last sample
                if (pin_rst_n)
                    next_s.st = hold_done ? ST_RUN : ST_HOLD;
            end
            ST_HOLD:
            begin
                // Reset out stays on until the hold time is met
                next_s.cnt = s.cnt + HOLD_W'(1);
                if (hold_done)
                    next_s.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (s.wd_en && !wd_expire)
                    next_s.wd_cnt = next_s.wd_cnt + 24'h000001;
                if (wd_expire)
                begin
                    // Expiry resets the block's own control state
                    next_s.st       = ST_HOLD;
                    next_s.cnt      = '0;
                    next_s.clk_code = `SRCC_CLK_RST;
                    next_s.wd_en    = 1'b0;
                    next_s.wd_ivl   = `SRCC_WDIVL_RST;
                    next_s.wd_cnt   = 24'h000000;
                    next_s.wd_fired = 1'b1;   // Set beats a clear
                end
            end
            default:
            begin
                next_s.st  = ST_STRAP;
                next_s.cnt = '0;
            end
        endcase

        // Chip reset pin restarts capture from any later state
        if (!pin_rst_n && s.st != ST_STRAP)
        begin
            next_s.st     = ST_STRAP;
            next_s.cnt    = '0;
            next_s.wd_en  = 1'b0;
            next_s.wd_cnt = 24'h000000;
            next_s.clk_code = `SRCC_CLK_RST;
            next_s.wd_ivl = `SRCC_WDIVL_RST;
        end
        if (next_s.st != ST_RUN)
            next_s.wd_cnt = 24'h000000;

        // Output level: asserted XOR polarity strap
        next_s.rst_out = (next_s.st != ST_RUN)
                         ^ next_s.strap.rst_pol;

        // Configuration outputs
        next_s.cfg.bank0_width     = next_s.strap.bank_width;
        next_s.cfg.pll_bypass      = next_s.strap.cpu_clk_byp;
        next_s.cfg.pll_freq_sel    = next_s.clk_code;
        next_s.cfg.pci_arb_en      = next_s.strap.host_bridge;
        next_s.cfg.pci_target_only = ~next_s.strap.host_bridge;
        next_s.cfg.factory_test    = next_s.strap.test_en;
        next_s.cfg.sdram_capture_fb = 1'b1;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s          <= '0;
            s.st       <= ST_STRAP;
            s.clk_code <= `SRCC_CLK_RST;
            s.wd_ivl   <= `SRCC_WDIVL_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign apb_rsp          = s.rsp;
    assign system_reset_out = s.rst_out;
    assign cfg              = s.cfg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_SAMPLE: assert property (
        s.st == ST_STRAP |=> s.strap == $past(pin_strap))
        else $error("strap not sampled during reset");

    AST_FROZEN: assert property (
        s.st == ST_RUN && $past(s.st) == ST_RUN |-> $stable(s.strap))
        else $error("strap changed while running");

    AST_WIDTH: assert property (
        s.st == ST_RUN |-> cfg.bank0_width == s.strap.bank_width)
        else $error("bank width not from strap");

    AST_POL: assert property (
        s.st == ST_RUN ##1 s.st == ST_RUN
        |-> system_reset_out == s.strap.rst_pol)
        else $error("reset out level wrong while running");

    AST_BYPASS: assert property (
        cfg.pll_bypass == s.strap.cpu_clk_byp)
        else $error("pll bypass not from strap");

    AST_GUEST: assert property (
        s.st == ST_RUN && !s.strap.host_bridge
        |-> !cfg.pci_arb_en && cfg.pci_target_only)
        else $error("guest mode arbiter enabled");

    AST_WDOG: assert property (
        wd_expire && pin_rst_n
        |=> s.st == ST_HOLD && s.cnt == '0 && s.wd_fired
            && system_reset_out == !s.strap.rst_pol)
        else $error("watchdog expiry did not reset");

    AST_HOLD: assert property (
        s.st != ST_RUN ##1 s.st == ST_RUN |-> $past(s.cnt) >= HOLD_CYC)
        else $error("reset out released before hold time");

    AST_FREQ: assert property (
        wr_acc && apb_req.paddr == `SRCC_OFS_CLKCTL
        && apb_req.pwdata[2:0] <= `SRCC_CLK_MAX && s.st == ST_RUN
        && !wd_expire && pin_rst_n
        |=> cfg.pll_freq_sel == $past(apb_req.pwdata[2:0]))
        else $error("clock setting not applied");

    COV_RUN:   cover property (s.st == ST_HOLD ##1 s.st == ST_RUN);
    COV_WDOG:  cover property (wd_expire);
    COV_GUEST: cover property (s.st == ST_RUN && !s.strap.host_bridge);

endmodule

`default_nettype wire

/* File: dv/srcc_board.sv */
// Purpose: Board side of the strap block: strap resistors, reset circuit
// Assumes: Straps are read by the block only while chip reset is low
// Notes:   Outside reset the dual-use pins carry a toggling pattern
`timescale 1ns/1ps
`default_nettype none

module srcc_board #(
    parameter int MIN_LOW = 256
) (
    // Clock
    input  wire logic       ref_clk,
    // Strap pins
    output logic      [1:0] boot_bank_width_strap,
    output logic            reset_out_polarity_strap,
    output logic            cpu_clock_source_strap,
    output logic            bridge_mode_strap,
    output logic            chip_test_enable,
    // Reset pin
    output logic            chip_reset_n
);
    // ------------------------------------------------------------
    // Strap levels and pin activity
    // ------------------------------------------------------------
    logic [5:0] straps;   // {width, polarity, clock, bridge, test}
    logic [4:0] pattern;  // Normal-function traffic on shared pins
    int         low_cnt;  // Cycles with chip reset held low

    initial
    begin
        straps       = 6'h00;
        pattern      = 5'h00;
        low_cnt      = 0;
        chip_reset_n = 1'b0;
    end

    // Shared pins flip every cycle once reset is released
    always @(posedge ref_clk)
    begin
        pattern <= chip_reset_n ? ~pattern : ~straps[5:1];
        low_cnt <= chip_reset_n ? 0 : low_cnt + 1;
    end

    // Straps only during reset, traffic otherwise
    assign {boot_bank_width_strap, reset_out_polarity_strap,
            cpu_clock_source_strap, bridge_mode_strap} =
           chip_reset_n ? pattern : straps[5:1];
    // Test pin is static; normal settings keep it low
    assign chip_test_enable = straps[0];

    // Assert chip reset with a new strap setting
    task automatic start(input logic [5:0] v);
        @(posedge ref_clk);
        straps       <= v;
        chip_reset_n <= 1'b0;
    endtask

    // Release only after the minimum low time
    task automatic release_reset();
        do
            @(posedge ref_clk);
        while (low_cnt < MIN_LOW);
        chip_reset_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the strap, reset and clock block
// Assumes: Short reset hold for simulation; APB waits on pready
// Notes:   Board model drives straps and the chip reset pin
`timescale 1ns/1ps
`default_nettype none
`include "srcc_map.svh"

module tb_top;
    import srcc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int HOLD = 20;     // Shortened reset-out hold
    localparam int CEIL = 20000;  // Timeout in clock cycles
    logic          ref_clk;
    logic          arst_n;
    srcc_apb_req_t req;
    srcc_apb_rsp_t apb_rsp;
    logic [1:0]    w_pin;
    logic          pol_pin, clk_pin, br_pin, te_pin, crst_n;
    logic          system_reset_out;
    srcc_cfg_t     cfg;
    logic [31:0]   rd;
    logic          err;
    int            fails, check_count, cycles, n;
    logic [5:0]    tab [4] = '{6'b01_0010, 6'b10_1100, 6'b11_0001,
                               6'b00_1010};
    logic [5:0]    v;

    // ------------------------------------------------------------
    // Clock, reset, timeout
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Cut a hang short
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == CEIL)
        begin
            fails++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Design and board
    // ------------------------------------------------------------
    srcc_top #(.HOLD_W(22), .RST_HOLD_CYC(HOLD)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .apb_req(req),
        .apb_rsp(apb_rsp), .boot_bank_width_strap(w_pin),
        .reset_out_polarity_strap(pol_pin),
        .cpu_clock_source_strap(clk_pin), .bridge_mode_strap(br_pin),
        .chip_test_enable(te_pin), .chip_reset_n(crst_n),
        .system_reset_out(system_reset_out), .cfg(cfg));

    srcc_board #(.MIN_LOW(256)) board (
        .ref_clk(ref_clk), .boot_bank_width_strap(w_pin),
        .reset_out_polarity_strap(pol_pin),
        .cpu_clock_source_strap(clk_pin), .bridge_mode_strap(br_pin),
        .chip_test_enable(te_pin), .chip_reset_n(crst_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        // Only the bench timeout ends this wait
        while (apb_rsp.pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Read and compare data
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                          input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, e, rd);
    endtask

    // Wait cycles and land between edges
    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        arst_n = 1'b0;
        req = '0;
        fails = 0;
        check_count = 0;
        cycles = 0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_chk(`SRCC_OFS_CLKCTL, 32'h4, "clkctl_rst");
        rd_chk(`SRCC_OFS_WDIVL, 32'hffffff, "wdivl_rst");
        // Leave the power-on capture so each pass starts from running
        board.release_reset();
        settle(30);
        // Every width code and both levels of each strap
        for (int i = 0; i < 4; i++)
        begin
            v = tab[i];
            apb(1'b1, `SRCC_OFS_CLKCTL, 32'h1);
            board.start(v);
            settle(40);
            check("rst_out_on", {31'h0, ~v[3]},
                  {31'h0, system_reset_out});
            board.release_reset();
            settle(30);
            check("rst_out_off", {31'h0, v[3]},
                  {31'h0, system_reset_out});
            check("cfg", {25'h0, v[5:4], v[2], v[1], ~v[1], v[0], 1'b1},
                  {25'h0, cfg.bank0_width, cfg.pll_bypass, cfg.pci_arb_en,
                   cfg.pci_target_only, cfg.factory_test,
                   cfg.sdram_capture_fb});
            rd_chk(`SRCC_OFS_STRAP, {26'h0, v}, "strap");
            rd_chk(`SRCC_OFS_CLKCTL, 32'h4, "clkctl_crst");
        end
        // Clock codes, values above the top code clamp
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, `SRCC_OFS_CLKCTL, 32'(c));
            rd_chk(`SRCC_OFS_CLKCTL, (c > 4) ? 32'h4 : 32'(c),
                   "clkctl");
            check("freq_sel", (c > 4) ? 32'h4 : 32'(c),
                  {29'h0, cfg.pll_freq_sel});
        end
        // Refused accesses
        apb(1'b1, `SRCC_OFS_STRAP, 32'h3f);
        check("ro_err", 32'h1, {31'h0, err});
        rd_chk(`SRCC_OFS_STRAP, {26'h0, v}, "strap_ro");
        apb(1'b0, 12'h014, 32'h0);
        check("unmap_err", 32'h1, {31'h0, err});
        check("unmap_rd", 32'h0, rd);
        // Watchdog expiry and reset-out hold
        apb(1'b1, `SRCC_OFS_CLKCTL, 32'h2);
        apb(1'b1, `SRCC_OFS_WDIVL, 32'h40);
        apb(1'b1, `SRCC_OFS_WDCTL, 32'h1);
        n = 0;
        while (system_reset_out !== ~v[3] && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        while (system_reset_out === ~v[3] && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("wd_hold", 32'h1,
              {31'h0, n >= HOLD && n <= HOLD + 3});
        rd_chk(`SRCC_OFS_CLKCTL, 32'h4, "clkctl_wd");
        rd_chk(`SRCC_OFS_STRAP, {26'h0, v}, "strap_wd");
        apb(1'b0, `SRCC_OFS_WDCTL, 32'h0);
        check("wd_fired", 32'h1, {31'h0, rd[`SRCC_WD_FIRE_BIT]});
        apb(1'b1, `SRCC_OFS_WDCTL, 32'h100);
        apb(1'b0, `SRCC_OFS_WDCTL, 32'h0);
        check("wd_clear", 32'h0, {31'h0, rd[`SRCC_WD_FIRE_BIT]});
        // Kick restarts the count: two edges counted before the read
        apb(1'b1, `SRCC_OFS_WDCTL, 32'h1);
        apb(1'b1, `SRCC_OFS_WDCTL, 32'h3);
        rd_chk(`SRCC_OFS_WDCNT, 32'h2, "wd_kick");
        finish_test();
    end
endmodule

`default_nettype wire
